// File: fpls_sched.sv
// Late-start fuel pulse scheduler with an AXI4-Lite register slave.
// Assumes the crank angle input is synchronous to aclk and counts 0..719.
//
// Function
// - Start passed by under 45 degrees begins the pulse at once.
// - A late pulse still lasts the full programmed length.
// - Start passed by 45 to 359 degrees skips this cycle's pulse.
// - After a skip, next cycle fires at the new start angle.
// - Cutoff ends pulse, rearms, sets flag held until host clears it.
// - Length cut below accumulated time ends the pulse at once.
// - Length raised above accumulated time extends the pulse.
// - Length counts 40 MHz ticks in 24 bits, wrapping larger values.
`timescale 1ns/100ps
`default_nettype none
`include "fpls_map.svh"

module fpls_sched #(
    parameter int ANGLE_W = `FPLS_ANGLE_W,
    parameter int DUR_W = `FPLS_DUR_W,
    parameter int CYCLE_CAD = `FPLS_CYCLE_CAD,
    parameter int HISTORY_CAD = `FPLS_HISTORY_CAD
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ANGLE_W-1:0] crank_angle_now,
    output logic fuel_cmd,
    output logic cutoff_reached_flag,
    output logic irq,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ********************************************************
    // Helpers
    // ********************************************************

    // Distance from a past angle to now, folded into one engine cycle.
    function automatic logic [ANGLE_W-1:0] behind(
        input logic [ANGLE_W-1:0] now,
        input logic [ANGLE_W-1:0] past
    );
        logic [ANGLE_W:0] d;
        d = {1'b0, now} - {1'b0, past};
        if (now < past) begin
            d = d + (ANGLE_W+1)'(CYCLE_CAD);
        end
        return d[ANGLE_W-1:0];
    endfunction

    // Byte-lane merge of a write onto an old register value.
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return m;
    endfunction

    // ********************************************************
    // Registers and state
    // ********************************************************

    logic enable_r;
    fpls_pkg::fpls_angles_type angles_r;
    logic [DUR_W-1:0] duration_r;
    logic [`FPLS_NUM_EVENTS-1:0] status_r;
    logic [`FPLS_NUM_EVENTS-1:0] mask_r;
    fpls_pkg::fpls_state_type state_r;
    fpls_pkg::fpls_state_type state_nxt;
    logic [DUR_W-1:0] accum_r;
    logic [2:0] phase_r;
    logic [ANGLE_W-1:0] prev_angle_r;
    logic aw_held_r;
    logic w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    // ********************************************************
    // Register write decode
    // ********************************************************

    // A write commits once address and data are both held.
    wire logic wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    wire logic wr_ctrl = wr_go && awaddr_r == `FPLS_ADDR_CTRL;
    wire logic wr_start = wr_go && awaddr_r == `FPLS_ADDR_START;
    wire logic wr_cut = wr_go && awaddr_r == `FPLS_ADDR_CUTOFF;
    wire logic wr_dur = wr_go && awaddr_r == `FPLS_ADDR_DURATION;
    wire logic wr_stat = wr_go && awaddr_r == `FPLS_ADDR_STATUS;
    wire logic wr_mask = wr_go && awaddr_r == `FPLS_ADDR_IRQ_MASK;
    wire logic wr_known = wr_ctrl || wr_start || wr_cut || wr_dur ||
        wr_stat || wr_mask;
    wire logic [31:0] start_m = merge(32'(angles_r.start), wdata_r, wstrb_r);
    wire logic [31:0] cut_m = merge(32'(angles_r.cutoff), wdata_r, wstrb_r);
    wire logic [31:0] dur_m = merge(32'(duration_r), wdata_r, wstrb_r);
    wire logic [31:0] ctrl_m = merge(32'(enable_r), wdata_r, wstrb_r);
    wire logic [31:0] mask_m = merge(32'(mask_r), wdata_r, wstrb_r);
    wire logic [31:0] clr_m = merge(32'h0000_0000, wdata_r, wstrb_r);

    // ********************************************************
    // Scheduling decisions
    // ********************************************************

    // Angle events: crossing means the crank moved onto the target.
    wire logic moved = crank_angle_now != prev_angle_r;
    wire logic at_start = moved && crank_angle_now == angles_r.start;
    wire logic at_cut = moved && crank_angle_now == angles_r.cutoff;
    // A new start angle that already lies behind the crank.
    wire logic [ANGLE_W-1:0] new_start = start_m[ANGLE_W-1:0];
    wire logic [ANGLE_W-1:0] lag = behind(crank_angle_now, new_start);
    wire logic start_moved = wr_start && new_start != angles_r.start;
    wire logic passed = start_moved && lag != '0 &&
        lag < ANGLE_W'(CYCLE_CAD / 2);
    wire logic late_go = passed && lag < ANGLE_W'(HISTORY_CAD);
    wire logic skip = passed && !late_go;
    // 40 MHz tick: two ticks in every five 100 MHz cycles.
    wire logic tick = phase_r == 3'd0 || phase_r == 3'd2;
    // Pulse ends when its length is reached, even if cut down mid-pulse.
    wire logic len_done = accum_r >= duration_r;
    wire logic fire = enable_r && state_r == fpls_pkg::ST_ARMED &&
        (at_start || late_go);

    // ********************************************************
    // Next state
    // ********************************************************

    // Pulse states; cutoff overrides everything and rearms.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fpls_pkg::ST_ARMED: begin
                if (fire) begin
                    state_nxt = fpls_pkg::ST_PULSE;
                end else if (skip) begin
                    state_nxt = fpls_pkg::ST_SPENT;
                end
            end
            fpls_pkg::ST_PULSE: begin
                if (len_done) begin
                    state_nxt = fpls_pkg::ST_SPENT;
                end
            end
            fpls_pkg::ST_SPENT: begin
                state_nxt = fpls_pkg::ST_SPENT;
            end
            default: begin
                state_nxt = fpls_pkg::ST_ARMED;
            end
        endcase
        if (at_cut) begin
            state_nxt = fpls_pkg::ST_ARMED;
        end
    end

    // Event bits that hardware raises this cycle.
    wire logic [`FPLS_NUM_EVENTS-1:0] ev = {
        state_r == fpls_pkg::ST_PULSE && state_nxt != fpls_pkg::ST_PULSE,
        skip && state_r == fpls_pkg::ST_ARMED,
        late_go && fire,
        at_cut
    };

    // ********************************************************
    // Scheduler flops
    // ********************************************************

    // Pulse state, accumulated length and the 40 MHz phase.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= fpls_pkg::ST_ARMED;
            accum_r <= '0;
            phase_r <= '0;
            prev_angle_r <= '0;
        end else begin
            state_r <= state_nxt;
            prev_angle_r <= crank_angle_now;
            phase_r <= (phase_r == 3'(`FPLS_TICK_DEN - 1)) ?
                3'd0 : phase_r + 3'd1;
            if (state_nxt != fpls_pkg::ST_PULSE) begin
                accum_r <= '0;
            end else if (tick) begin
                accum_r <= accum_r + 1'b1;
            end
        end
    end

    // Outputs straight from flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuel_cmd <= 1'b0;
            irq <= 1'b0;
        end else begin
            fuel_cmd <= state_nxt == fpls_pkg::ST_PULSE;
            irq <= |(status_r & mask_r);
        end
    end

    // ********************************************************
    // Software registers
    // ********************************************************

    // Writable settings; the length keeps its low 24 bits only.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_r <= 1'b0;
            angles_r <= '0;
            duration_r <= '0;
            mask_r <= '0;
        end else begin
            if (wr_ctrl) begin
                enable_r <= ctrl_m[`FPLS_BIT_ENABLE];
            end
            if (wr_start) begin
                angles_r.start <= new_start;
            end
            if (wr_cut) begin
                angles_r.cutoff <= cut_m[ANGLE_W-1:0];
            end
            if (wr_dur) begin
                duration_r <= dur_m[DUR_W-1:0];
            end
            if (wr_mask) begin
                mask_r <= mask_m[`FPLS_NUM_EVENTS-1:0];
            end
        end
    end

    // Sticky status: write one to clear, a new event wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= '0;
            cutoff_reached_flag <= 1'b0;
        end else begin
            status_r <= (status_r & ~(wr_stat ?
                clr_m[`FPLS_NUM_EVENTS-1:0] : '0)) | ev;
            cutoff_reached_flag <= (cutoff_reached_flag &&
                !(wr_stat && clr_m[`FPLS_BIT_CUTOFF])) || at_cut;
        end
    end

    // ********************************************************
    // AXI4-Lite handshakes
    // ********************************************************

    // Address and data are taken in either order, then answered.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FPLS_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? `FPLS_RESP_OKAY : `FPLS_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end
        end
    end

    // Read mux of all registers and live state.
    wire logic [11:0] ra = {s_axi_araddr[11:2], 2'b00};
    wire logic rd_known = ra <= `FPLS_ADDR_STATE;
    wire logic [31:0] rd_val =
        ra == `FPLS_ADDR_CTRL ? 32'(enable_r) :
        ra == `FPLS_ADDR_START ? 32'(angles_r.start) :
        ra == `FPLS_ADDR_CUTOFF ? 32'(angles_r.cutoff) :
        ra == `FPLS_ADDR_DURATION ? 32'(duration_r) :
        ra == `FPLS_ADDR_ANGLE ? 32'(crank_angle_now) :
        ra == `FPLS_ADDR_STATUS ? 32'(status_r) :
        ra == `FPLS_ADDR_IRQ_MASK ? 32'(mask_r) :
        ra == `FPLS_ADDR_STATE ? {30'h0000_0000, state_r} : 32'h0000_0000;

    // One read at a time; data ready the cycle after the address.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `FPLS_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_known ? `FPLS_RESP_OKAY : `FPLS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// File: fpls_map.svh
// Constants for the late-start fuel pulse scheduler: offsets, fields, counts.
// Assumes a 100 MHz fabric clock and 32-bit AXI4-Lite register words.
`ifndef FPLS_MAP_SVH
`define FPLS_MAP_SVH

// Register byte addresses.
`define FPLS_ADDR_CTRL      12'h000
`define FPLS_ADDR_START     12'h004
`define FPLS_ADDR_CUTOFF    12'h008
`define FPLS_ADDR_DURATION  12'h00C
`define FPLS_ADDR_ANGLE     12'h010
`define FPLS_ADDR_STATUS    12'h014
`define FPLS_ADDR_IRQ_MASK  12'h018
`define FPLS_ADDR_STATE     12'h01C

// Status and mask bit positions.
`define FPLS_BIT_CUTOFF     0
`define FPLS_BIT_LATE       1
`define FPLS_BIT_SKIP       2
`define FPLS_BIT_DONE       3
`define FPLS_NUM_EVENTS     4

// Control bit positions.
`define FPLS_BIT_ENABLE     0

// Angle and timing figures.
`define FPLS_HISTORY_CAD    45
`define FPLS_CYCLE_CAD      720
`define FPLS_ANGLE_W        10
`define FPLS_DUR_W          24
`define FPLS_CLK_HZ         100000000
`define FPLS_TICK_HZ        40000000
// Phase accumulator step: 40 MHz ticks out of a 100 MHz clock, per 5 cycles.
`define FPLS_TICK_NUM       (`FPLS_TICK_HZ / 20000000)
`define FPLS_TICK_DEN       (`FPLS_CLK_HZ / 20000000)

// AXI responses.
`define FPLS_RESP_OKAY      2'b00
`define FPLS_RESP_SLVERR    2'b10

`endif

// File: fpls_pkg.sv
// Types shared by the late-start fuel pulse scheduler.
// Assumes fpls_map.svh is compiled alongside.
`default_nettype none
package fpls_pkg;

    // Scheduler states.
    typedef enum logic [1:0] {
        ST_ARMED,
        ST_PULSE,
        ST_SPENT
    } fpls_state_type;

    // Angle settings that travel together.
    typedef struct packed {
        logic [9:0] start;
        logic [9:0] cutoff;
    } fpls_angles_type;

endpackage

`default_nettype wire

// File: fpls_crank_model.sv
// Crank position source that stands in for the engine position tracker.
// Assumes one aclk domain; the bench asks for each one-degree step.
`timescale 1ns/100ps
`default_nettype none
module fpls_crank_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic step,
    output logic [9:0] angle
);
    // One degree per requested edge, wrapping from 719 back to 0.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            angle <= 10'h000;
        end else if (step) begin
            angle <= (angle == 10'h2cf) ? 10'h000 : angle + 10'h001;
        end
    end
endmodule
`default_nettype wire

// File: fpls_sched_assertions.sv
// Bus and scheduling checks bound onto the fuel pulse scheduler.
// Assumes one aclk domain with a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
`include "fpls_map.svh"
module fpls_sched_assertions #(
    parameter int ANGLE_W = `FPLS_ANGLE_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ANGLE_W-1:0] crank_angle_now,
    input wire logic fuel_cmd,
    input wire logic cutoff_reached_flag,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [ANGLE_W-1:0] crank_r;
    logic [2:0] cause_r;
    logic cause_now;
    // A crank step or a register write is the only thing that may fire.
    assign cause_now = (crank_angle_now != crank_r) ||
        (s_axi_wvalid && s_axi_wready);
    // Short history of causes, since the start lands a few edges later.
    always_ff @(posedge aclk) begin
        crank_r <= crank_angle_now;
        cause_r <= {cause_r[1:0], cause_now};
    end
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence w_taken;
        s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    write_answer_a: assert property (w_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write got no response");
    bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("write response repeated");
    read_answer_a: assert property (ar_taken |-> ##[1:2] s_axi_rvalid)
        else $error("read got no data");
    rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid) else $error("read data repeated");
    ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("address ready held");
    slverr_zero_a: assert property (s_axi_rvalid &&
        s_axi_rresp == `FPLS_RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
        else $error("refused read returned data");
    flag_clear_a: assert property ($fell(cutoff_reached_flag) |->
        $past(s_axi_wvalid && s_axi_wready) ||
        $past(s_axi_wvalid && s_axi_wready, 2))
        else $error("cutoff flag fell without a write");
    cutoff_stop_a: assert property ($rose(cutoff_reached_flag) |->
        ##[0:1] !fuel_cmd) else $error("pulse ran past cutoff");
    pulse_cause_a: assert property ($rose(fuel_cmd) |->
        cause_now || (|cause_r)) else $error("pulse started unprompted");
endmodule
bind fpls_sched fpls_sched_assertions #(.ANGLE_W(ANGLE_W)) u_sva (
    .aclk, .aresetn, .crank_angle_now, .fuel_cmd, .cutoff_reached_flag,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// File: fpls_sched_test.sv
// Self-checking bench for the fuel pulse scheduler, acting as host.
// Assumes the crank model and the bound checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none
`include "fpls_map.svh"
module fpls_sched_test;
    localparam int LIMIT = 10000;
    localparam int CYC = `FPLS_TICK_DEN;
    localparam int TK = `FPLS_TICK_NUM;
    localparam logic [1:0] OK = `FPLS_RESP_OKAY;
    localparam logic [1:0] ERR = `FPLS_RESP_SLVERR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic step = 1'b0;
    logic clr = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [9:0] crank;
    logic fuel_cmd, flag, irq, fuel_q, awready, wready, bvalid;
    logic arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, hi_cnt, pulses;
    int mismatches = 0, total_checks = 0, cyc = 0;
    always #5 aclk = ~aclk;
    fpls_crank_model u_crank (.aclk(aclk), .aresetn(aresetn), .step(step),
        .angle(crank));
    fpls_sched DUT (.aclk(aclk), .aresetn(aresetn), .crank_angle_now(crank),
        .fuel_cmd(fuel_cmd), .cutoff_reached_flag(flag), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // Pulse width and pulse count monitor, plus the hang guard.
    always @(posedge aclk) begin
        fuel_q <= fuel_cmd;
        hi_cnt <= clr ? 32'h0 : hi_cnt + {31'h0, fuel_cmd};
        pulses <= clr ? 32'h0 : pulses + {31'h0, fuel_cmd && !fuel_q};
        cyc = cyc + 1;
        if (cyc == LIMIT) begin
            mismatches = mismatches + 1;
            stop_test();
        end
    end
    // ****************
    // Tasks
    // ****************
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Compares within a tolerance; an unknown never matches.
    task automatic chk(input logic [31:0] got, exp, input int tol);
        total_checks++;
        if (^got === 1'bx || got + tol < exp || got > exp + tol) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, 0);
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, msk,
        input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata & msk, ed, 0);
        chk({30'h0, rresp}, {30'h0, er}, 0);
        @(posedge aclk);
    endtask
    task automatic spin(input int n);
        step <= 1'b1;
        repeat (n) @(posedge aclk);
        step <= 1'b0;
    endtask
    task automatic zero();
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        rd(`FPLS_ADDR_CTRL, 32'h0, 32'hffff_ffff, OK);
        rd(`FPLS_ADDR_STATUS, 32'h0, 32'hffff_ffff, OK);
        rd(`FPLS_ADDR_ANGLE, 32'h0, 32'hffff_ffff, OK);
        rd(`FPLS_ADDR_STATE, 32'h0, 32'hffff_ffff, OK);
        wr(`FPLS_ADDR_ANGLE, 32'h0000_0001, ERR);
        wr(12'h040, 32'h0000_0001, ERR);
        rd(12'h040, 32'h0, 32'hffff_ffff, ERR);
        $display("Register test done");
    endtask
    task automatic t_fire();
        wr(`FPLS_ADDR_CUTOFF, 32'h0000_00c8, OK);
        wr(`FPLS_ADDR_START, 32'h0000_0064, OK);
        wr(`FPLS_ADDR_DURATION, 32'h0100_000a, OK);
        wr(`FPLS_ADDR_IRQ_MASK, 32'h0000_0000, OK);
        wr(`FPLS_ADDR_CTRL, 32'h0000_0001, OK);
        zero();
        spin(100);
        repeat (40) @(posedge aclk);
        chk(hi_cnt, 10 * CYC / TK, 2);
        spin(100);
        repeat (4) @(posedge aclk);
        chk({31'h0, flag}, 1, 0);
        chk({31'h0, irq}, 0, 0);
        wr(`FPLS_ADDR_IRQ_MASK, 32'h0000_0001, OK);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 1, 0);
        wr(`FPLS_ADDR_STATUS, 32'h0000_0001, OK);
        repeat (2) @(posedge aclk);
        chk({30'h0, flag, irq}, 0, 0);
        $display("Normal pulse test done");
    endtask
    task automatic t_late();
        wr(`FPLS_ADDR_CTRL, 32'h0000_0000, OK);
        wr(`FPLS_ADDR_START, 32'h0000_012c, OK);
        spin(530);
        wr(`FPLS_ADDR_CTRL, 32'h0000_0001, OK);
        zero();
        wr(`FPLS_ADDR_START, 32'h0000_02bc, OK);
        repeat (3) @(posedge aclk);
        chk({31'h0, fuel_cmd}, 1, 0);
        repeat (40) @(posedge aclk);
        chk(pulses, 1, 0);
        chk(hi_cnt, 10 * CYC / TK, 2);
        rd(`FPLS_ADDR_STATUS, 32'h0000_000a, 32'h0000_000f, OK);
        $display("Late start test done");
    endtask
    task automatic t_skip();
        spin(190);
        wr(`FPLS_ADDR_STATUS, 32'h0000_000f, OK);
        spin(100);
        zero();
        wr(`FPLS_ADDR_START, 32'h0000_00e6, OK);
        repeat (40) @(posedge aclk);
        chk(pulses, 0, 0);
        rd(`FPLS_ADDR_STATUS, 32'h0000_0004, 32'h0000_000f, OK);
        spin(649);
        chk(pulses, 0, 0);
        spin(1);
        repeat (4) @(posedge aclk);
        chk({31'h0, fuel_cmd}, 1, 0);
        $display("Skip test done");
    endtask
    task automatic t_len();
        wr(`FPLS_ADDR_START, 32'h0000_0104, OK);
        wr(`FPLS_ADDR_DURATION, 32'h0000_0064, OK);
        spin(30);
        repeat (20) @(posedge aclk);
        chk({31'h0, fuel_cmd}, 1, 0);
        wr(`FPLS_ADDR_DURATION, 32'h0000_0004, OK);
        repeat (2) @(posedge aclk);
        chk({31'h0, fuel_cmd}, 0, 0);
        zero();
        spin(720);
        wr(`FPLS_ADDR_DURATION, 32'h0000_0014, OK);
        repeat (60) @(posedge aclk);
        chk(hi_cnt, 20 * CYC / TK, 3);
        $display("Length change test done");
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_fire();
        t_late();
        t_skip();
        t_len();
        stop_test();
    end
endmodule
`default_nettype wire
